// file: mbw_defs.svh
// Constants for the serial-link point map and watchdog block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MBW_DEFS_SVH
`define MBW_DEFS_SVH

// ==========================================================================
// Timing
`define MBW_CLK_PERIOD_NS   8
`define MBW_SEC_NS          1000000000
`define MBW_BAUD            4800
`define MBW_DATA_BITS       4'h8
`define MBW_STOP_BITS       2'h2
`define MBW_PARITY_EN       1'b0

// ==========================================================================
// Point map
`define MBW_COIL_BASE       16'h0001
`define MBW_COIL_NUM        16'h0010
`define MBW_INST_BASE       16'h2711
`define MBW_INST_NUM        16'h0010
`define MBW_IREG_BASE       16'h7531
`define MBW_IREG_NUM        16'h0008
`define MBW_HREG_BASE       16'h9c41
`define MBW_HREG_NUM        16'h0004
`define MBW_RAW_MAX         16'h7fff

// ==========================================================================
// Configuration limits and reset values
`define MBW_WD_TMO_MIN      16'h000a
`define MBW_WD_TMO_RST      16'h000a
`define MBW_STATION_RST     8'h00
`define MBW_STATION_NONE    8'h00

// ==========================================================================
// Exception codes
`define MBW_EXC_NONE        8'h00
`define MBW_EXC_FUNC        8'h01
`define MBW_EXC_ADDR        8'h02
`define MBW_EXC_VALUE       8'h03

`endif

// file: mbw_master_model.sv
// Behavioural link master: one query at a time, retried on silence.
// Assumes one clock and answers within RSP_WAIT cycles of the query.
`timescale 1ns/1ps
`default_nettype none

module mbw_master_model #(
  parameter int RETRIES  = 2,
  parameter int RSP_WAIT = 4
) (
  input  wire logic              clk_sys,
  input  wire mbw_pkg::mbw_rsp_t rsp,
  output mbw_pkg::mbw_req_t      req
);
  // ==========================================================================
  // Query task with retries.
  task automatic query(input mbw_pkg::mbw_req_t q, output mbw_pkg::mbw_rsp_t r,
                       output logic got);
    got = 1'b0;
    r   = '0;
    for (int t = 0; t <= RETRIES && !got; t++) begin
      @(posedge clk_sys);
      req <= q;
      @(posedge clk_sys);
      req <= {1'b0, ~q[$bits(q)-2:0]};
      for (int w = 0; w < RSP_WAIT && !got; w++) begin
        #1;
        if (rsp.valid === 1'b1) begin
          got = 1'b1;
          r   = rsp;
        end else begin
          @(posedge clk_sys);
        end
      end
    end
  endtask : query

  initial req = '0;
endmodule : mbw_master_model
`default_nettype wire

// file: mbw_pkg.sv
// Types shared by the point map and watchdog block.
// Assumes mbw_defs.svh is on the include path.
`include "mbw_defs.svh"

package mbw_pkg;

  // ========================================================================
  // Decoded query from the link and its answer.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  unit;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbw_req_t;

  typedef struct packed {
    logic        valid;
    logic        from_store;
    logic [7:0]  exc;
    logic [15:0] rdata;
  } mbw_rsp_t;

  // ========================================================================
  // Configuration load and stored-status update.
  typedef struct packed {
    logic        wd_en;
    logic [15:0] wd_timeout;
    logic [7:0]  station;
  } mbw_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  unit;
    logic [15:0] status;
  } mbw_upd_t;

  // ========================================================================
  // Fixed character format of the serial link.
  typedef struct packed {
    logic [15:0] bit_cycles;
    logic [3:0]  data_bits;
    logic        parity_en;
    logic [1:0]  stop_bits;
  } mbw_fmt_t;

  typedef enum logic [1:0] {
    MBW_WD_OFF   = 2'h0,
    MBW_WD_RUN   = 2'h1,
    MBW_WD_ALARM = 2'h3
  } mbw_wd_state_t;

endpackage : mbw_pkg

// file: mbw_point_map.sv
// Serial-link I/O point map with link watchdog and status store.
// Assumes queries arrive already framed and decoded, synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "mbw_defs.svh"

module mbw_point_map #(
  parameter int SEC_CYCLES = `MBW_SEC_NS / `MBW_CLK_PERIOD_NS
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire mbw_pkg::mbw_req_t   req,
  output mbw_pkg::mbw_rsp_t        rsp,
  output mbw_pkg::mbw_req_t        fwd,
  input  wire logic                cfg_wr,
  input  wire mbw_pkg::mbw_cfg_t   cfg,
  input  wire logic                rbe_en,
  input  wire mbw_pkg::mbw_upd_t   upd,
  input  wire logic [15:0]         din_pin,
  input  wire logic [7:0][15:0]    ain_raw,
  output logic      [15:0]         dout_on,
  output logic      [3:0][15:0]    aout_raw,
  output logic                     wd_alarm,
  output mbw_pkg::mbw_fmt_t        link_fmt
);

  localparam int BIT_CYCLES = `MBW_SEC_NS / (`MBW_CLK_PERIOD_NS * `MBW_BAUD);

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] base,
                                  input logic [15:0] num);
    in_rng = (a >= base) && (a < base + num);
  endfunction : in_rng

  function automatic logic [15:0] sat_raw(input logic [15:0] v);
    sat_raw = (v > `MBW_RAW_MAX) ? `MBW_RAW_MAX : v;
  endfunction : sat_raw

  // ========================================================================
  // Configuration.
  logic [15:0]           dout_reg;
  logic [3:0][15:0]      aout_reg;
  logic                  wd_en_reg;
  logic [15:0]           wd_timeout_reg;
  logic [7:0]            station_reg;
  logic [15:0]           tmo_next;

  assign tmo_next = (cfg.wd_timeout < `MBW_WD_TMO_MIN) ? `MBW_WD_TMO_MIN : cfg.wd_timeout;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wd_en_reg      <= 1'b0;
      wd_timeout_reg <= `MBW_WD_TMO_RST;
      station_reg    <= `MBW_STATION_RST;
    end else if (cfg_wr) begin
      wd_en_reg      <= cfg.wd_en;
      wd_timeout_reg <= tmo_next;
      if (cfg.station != `MBW_STATION_NONE) begin
        station_reg <= cfg.station;
      end
    end
  end

  // ========================================================================
  // Point decode.
  wire       own     = req.valid && (station_reg != `MBW_STATION_NONE)
                       && (req.unit == station_reg);
  wire       foreign = req.valid && !own;
  wire       is_coil = in_rng(req.addr, `MBW_COIL_BASE, `MBW_COIL_NUM);
  wire       is_inst = in_rng(req.addr, `MBW_INST_BASE, `MBW_INST_NUM);
  wire       is_ireg = in_rng(req.addr, `MBW_IREG_BASE, `MBW_IREG_NUM);
  wire       is_hreg = in_rng(req.addr, `MBW_HREG_BASE, `MBW_HREG_NUM);
  wire [15:0] off_coil = req.addr - `MBW_COIL_BASE;
  wire [15:0] off_inst = req.addr - `MBW_INST_BASE;
  wire [15:0] off_ireg = req.addr - `MBW_IREG_BASE;
  wire [15:0] off_hreg = req.addr - `MBW_HREG_BASE;
  wire       ro_point = is_inst || is_ireg;
  wire       bad_coil = is_coil && req.write && (req.wdata > 16'h0001);
  wire       bad_hreg = is_hreg && req.write && (req.wdata > `MBW_RAW_MAX);
  wire       coil_wr  = own && req.write && is_coil && !bad_coil;
  wire       hreg_wr  = own && req.write && is_hreg && !bad_hreg;

  wire [7:0] exc_next =
      !(is_coil || ro_point || is_hreg) ? `MBW_EXC_ADDR :
      (req.write && ro_point)           ? `MBW_EXC_FUNC :
      (bad_coil || bad_hreg)            ? `MBW_EXC_VALUE : `MBW_EXC_NONE;

  wire [15:0] rd_next =
      is_coil ? {15'h0000, dout_reg[off_coil[3:0]]} :
      is_inst ? {15'h0000, ~din_pin[off_inst[3:0]]} :
      is_ireg ? sat_raw(ain_raw[off_ireg[2:0]]) :
      is_hreg ? aout_reg[off_hreg[1:0]] : 16'h0000;

  // ========================================================================
  // Outputs and answer.
  logic                  rsp_v_reg;
  logic                  rsp_mem_reg;
  logic [7:0]            rsp_exc_reg;
  logic [15:0]           rsp_dat_reg;
  mbw_pkg::mbw_req_t     fwd_reg;
  logic [15:0]           mem_rdata;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dout_reg <= 16'h0000;
      aout_reg <= '0;
    end else begin
      if (coil_wr) dout_reg[off_coil[3:0]] <= req.wdata[0];
      if (hreg_wr) aout_reg[off_hreg[1:0]] <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rsp_v_reg   <= 1'b0;
      rsp_mem_reg <= 1'b0;
      rsp_exc_reg <= `MBW_EXC_NONE;
      rsp_dat_reg <= 16'h0000;
      fwd_reg     <= '0;
    end else begin
      rsp_v_reg   <= own || (foreign && rbe_en);
      rsp_mem_reg <= foreign && rbe_en;
      rsp_exc_reg <= own ? exc_next : `MBW_EXC_NONE;
      rsp_dat_reg <= (own && exc_next == `MBW_EXC_NONE) ? rd_next : 16'h0000;
      fwd_reg     <= req;
      fwd_reg.valid <= foreign && !rbe_en;
    end
  end

  mbw_status_mem #(
    .AW (8),
    .DW (16)
  ) u_store (
    .clk_sys (clk_sys),
    .wr_en   (upd.valid),
    .wr_addr (upd.unit),
    .wr_data (upd.status),
    .rd_addr (req.unit),
    .rd_data (mem_rdata)
  );

  assign rsp.valid      = rsp_v_reg;
  assign rsp.from_store = rsp_mem_reg;
  assign rsp.exc        = rsp_exc_reg;
  assign rsp.rdata      = rsp_mem_reg ? mem_rdata : rsp_dat_reg;
  assign fwd            = fwd_reg;
  assign aout_raw       = aout_reg;

  // ========================================================================
  // Link watchdog.
  mbw_pkg::mbw_wd_state_t wd_state_reg;
  mbw_pkg::mbw_wd_state_t wd_state_next;
  logic [31:0]           tick_reg;
  logic [15:0]           sec_reg;
  wire                   sec_tick = (tick_reg == 32'(SEC_CYCLES - 1));
  wire                   expired  = (sec_reg >= wd_timeout_reg);

  always_comb begin
    case (wd_state_reg)
      mbw_pkg::MBW_WD_OFF:   wd_state_next = wd_en_reg ? mbw_pkg::MBW_WD_RUN : mbw_pkg::MBW_WD_OFF;
      mbw_pkg::MBW_WD_RUN:   wd_state_next = !wd_en_reg ? mbw_pkg::MBW_WD_OFF :
                                             (expired && !req.valid) ? mbw_pkg::MBW_WD_ALARM :
                                             mbw_pkg::MBW_WD_RUN;
      mbw_pkg::MBW_WD_ALARM: wd_state_next = !wd_en_reg ? mbw_pkg::MBW_WD_OFF :
                                             req.valid ? mbw_pkg::MBW_WD_RUN :
                                             mbw_pkg::MBW_WD_ALARM;
      default:               wd_state_next = mbw_pkg::MBW_WD_OFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wd_state_reg <= mbw_pkg::MBW_WD_OFF;
      tick_reg     <= 32'h0000_0000;
      sec_reg      <= 16'h0000;
    end else begin
      wd_state_reg <= wd_state_next;
      if (req.valid || wd_state_reg == mbw_pkg::MBW_WD_OFF) begin
        tick_reg <= 32'h0000_0000;
        sec_reg  <= 16'h0000;
      end else if (sec_tick) begin
        tick_reg <= 32'h0000_0000;
        if (sec_reg != 16'hffff) sec_reg <= sec_reg + 16'h0001;
      end else begin
        tick_reg <= tick_reg + 32'h0000_0001;
      end
    end
  end

  assign wd_alarm   = (wd_state_reg == mbw_pkg::MBW_WD_ALARM);
  assign dout_on    = {dout_reg[15:1], dout_reg[0] | wd_alarm};
  assign link_fmt.bit_cycles = 16'(BIT_CYCLES);
  assign link_fmt.data_bits  = `MBW_DATA_BITS;
  assign link_fmt.parity_en  = `MBW_PARITY_EN;
  assign link_fmt.stop_bits  = `MBW_STOP_BITS;

  // ========================================================================
  // Checks.
  a_alarm_out_on: assert property (@(posedge clk_sys) disable iff (rst)
    wd_alarm |-> dout_on[0] && $past(wd_en_reg)) else $error("alarm without output one");
  a_wd_reset_off: assert property (@(posedge clk_sys) disable iff (rst)
    $past(rst) |-> !wd_en_reg && !wd_alarm) else $error("watchdog enabled after reset");
  a_tmo_floor: assert property (@(posedge clk_sys) disable iff (rst)
    wd_timeout_reg >= `MBW_WD_TMO_MIN) else $error("timeout below minimum");
  a_query_restart: assert property (@(posedge clk_sys) disable iff (rst)
    req.valid |=> sec_reg == 16'h0000 && !wd_alarm) else $error("query did not restart count");
  a_station_zero_kept: assert property (@(posedge clk_sys) disable iff (rst)
    cfg_wr && cfg.station == `MBW_STATION_NONE |=> $stable(station_reg))
    else $error("station set to zero");
  a_unmapped_exc: assert property (@(posedge clk_sys) disable iff (rst)
    own && !(is_coil || is_inst || is_ireg || is_hreg) |=> rsp.exc == `MBW_EXC_ADDR)
    else $error("unmapped address answered");
  a_input_readonly: assert property (@(posedge clk_sys) disable iff (rst)
    own && req.write && ro_point |=> rsp.exc == `MBW_EXC_FUNC && $stable(aout_reg)
    && $stable(dout_reg)) else $error("input point written");
  a_coil_write: assert property (@(posedge clk_sys) disable iff (rst)
    coil_wr |=> dout_reg[$past(off_coil[3:0])] == $past(req.wdata[0]))
    else $error("coil write lost");
  a_ain_range: assert property (@(posedge clk_sys) disable iff (rst)
    own && is_ireg && !req.write |=> rsp.rdata <= `MBW_RAW_MAX) else $error("raw above max");
  a_aout_range: assert property (@(posedge clk_sys) disable iff (rst)
    aout_reg[0] <= `MBW_RAW_MAX && aout_reg[3] <= `MBW_RAW_MAX) else $error("output above max");
  a_store_answer: assert property (@(posedge clk_sys) disable iff (rst)
    foreign && rbe_en |=> rsp.valid && rsp.from_store && !fwd.valid)
    else $error("store poll not answered");

  c_alarm_raised: cover property (@(posedge clk_sys) disable iff (rst) $rose(wd_alarm));
  c_coil_write:   cover property (@(posedge clk_sys) disable iff (rst) coil_wr);
  c_store_poll:   cover property (@(posedge clk_sys) disable iff (rst) foreign && rbe_en);

endmodule : mbw_point_map

`default_nettype wire

// file: mbw_status_mem.sv
// Last-known status store, one word per remote unit.
// Assumes one clock and a synchronous active-high reset upstream.
`timescale 1ns/1ps
`default_nettype none

module mbw_status_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input  wire logic          clk_sys,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem_reg [0:(1<<AW)-1];

  // ========================================================================
  // Write port and registered read port.
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
    rd_data <= mem_reg[rd_addr];
  end

endmodule : mbw_status_mem

`default_nettype wire

// file: testbench.sv
// Self-checking bench for the point map and link watchdog.
// Assumes the master model file is compiled first.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic              clk_sys, rst, cfg_wr, rbe_en, got, wd_alarm;
  mbw_pkg::mbw_req_t req, fwd;
  mbw_pkg::mbw_rsp_t rsp, r;
  mbw_pkg::mbw_cfg_t cfg;
  mbw_pkg::mbw_upd_t upd;
  mbw_pkg::mbw_fmt_t link_fmt;
  logic [15:0]       din_pin, dout_on;
  logic [7:0][15:0]  ain_raw;
  logic [3:0][15:0]  aout_raw;
  int                fails, cmp_count, fwd_cnt, n;

  mbw_point_map #(.SEC_CYCLES(10)) i_dut (.clk_sys(clk_sys), .rst(rst), .req(req),
    .rsp(rsp), .fwd(fwd), .cfg_wr(cfg_wr), .cfg(cfg), .rbe_en(rbe_en), .upd(upd),
    .din_pin(din_pin), .ain_raw(ain_raw), .dout_on(dout_on), .aout_raw(aout_raw),
    .wd_alarm(wd_alarm), .link_fmt(link_fmt));
  mbw_master_model i_master (.clk_sys(clk_sys), .rsp(rsp), .req(req));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) if (fwd.valid === 1'b1) fwd_cnt++;

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic ask(input logic w, input logic [7:0] u, input logic [15:0] a,
                     input logic [15:0] d, input logic [7:0] ex, input logic [15:0] rd);
    i_master.query('{valid: 1'b1, write: w, unit: u, addr: a, wdata: d}, r, got);
    chk("answered", 32'h1, {31'h0, got});
    if (got !== 1'b1) results();
    chk("exc", {24'h0, ex}, {24'h0, r.exc});
    chk("rdata", {16'h0, rd}, {16'h0, r.rdata});
  endtask : ask

  task automatic load(input logic en, input logic [15:0] tmo, input logic [7:0] st);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg    <= '{wd_en: en, wd_timeout: tmo, station: st};
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask : load

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    chk("dout_on", 32'h0, {16'h0, dout_on});
    chk("wd_alarm", 32'h0, {31'h0, wd_alarm});
    chk("link_fmt", {9'h0, 16'h65b9, 4'h8, 1'b0, 2'h2}, {9'h0, link_fmt});
    i_master.query('{valid: 1'b1, write: 1'b1, unit: 8'h00, addr: 16'h0001,
                     wdata: 16'h0001}, r, got);
    chk("unanswered", 32'h0, {31'h0, got});
    chk("fwd_count", 32'h3, fwd_cnt);
    chk("dout_on", 32'h0, {16'h0, dout_on});
  endtask : t_reset

  task automatic t_points();
    load(1'b0, 16'h000a, 8'h05);
    load(1'b0, 16'h000a, 8'h00);
    ask(1'b1, 8'h05, 16'h0001, 16'h0001, 8'h00, 16'h0000);
    ask(1'b1, 8'h05, 16'h0010, 16'h0001, 8'h00, 16'h0000);
    ask(1'b1, 8'h05, 16'h0001, 16'h0002, 8'h03, 16'h0000);
    ask(1'b0, 8'h05, 16'h0010, 16'h0000, 8'h00, 16'h0001);
    chk("dout_on", 32'h8001, {16'h0, dout_on});
    ask(1'b1, 8'h05, 16'h0011, 16'h0001, 8'h02, 16'h0000);
    ask(1'b0, 8'h05, 16'h2711, 16'h0000, 8'h00, 16'h0001);
    ask(1'b0, 8'h05, 16'h2720, 16'h0000, 8'h00, 16'h0000);
    ask(1'b1, 8'h05, 16'h2711, 16'h0000, 8'h01, 16'h0000);
    ask(1'b0, 8'h05, 16'h7538, 16'h0000, 8'h00, 16'h7fff);
    ask(1'b1, 8'h05, 16'h7531, 16'h0000, 8'h01, 16'h0000);
    ask(1'b0, 8'h05, 16'h7531, 16'h0000, 8'h00, 16'h1999);
    ask(1'b1, 8'h05, 16'h9c44, 16'h1999, 8'h00, 16'h0000);
    ask(1'b1, 8'h05, 16'h9c44, 16'h8000, 8'h03, 16'h0000);
    ask(1'b1, 8'h05, 16'h9c45, 16'h0001, 8'h02, 16'h0000);
    ask(1'b0, 8'h05, 16'h9c44, 16'h0000, 8'h00, 16'h1999);
    chk("aout_raw", 32'h1999, {16'h0, aout_raw[3]});
    ask(1'b1, 8'h05, 16'h0001, 16'h0000, 8'h00, 16'h0001);
    chk("dout_on", 32'h8000, {16'h0, dout_on});
  endtask : t_points

  task automatic t_store();
    @(posedge clk_sys);
    upd    <= '{valid: 1'b1, unit: 8'h09, status: 16'h1234};
    rbe_en <= 1'b1;
    @(posedge clk_sys);
    upd    <= '0;
    ask(1'b0, 8'h09, 16'h0001, 16'h0000, 8'h00, 16'h1234);
    chk("from_store", 32'h1, {31'h0, r.from_store});
    chk("fwd_count", 32'h3, fwd_cnt);
    @(posedge clk_sys);
    rbe_en <= 1'b0;
  endtask : t_store

  task automatic t_wdog();
    load(1'b1, 16'h0003, 8'h05);
    ask(1'b0, 8'h05, 16'h0001, 16'h0000, 8'h00, 16'h0000);
    repeat (80) @(posedge clk_sys);
    ask(1'b0, 8'h05, 16'h0001, 16'h0000, 8'h00, 16'h0000);
    repeat (80) @(posedge clk_sys);
    #1;
    chk("wd_alarm", 32'h0, {31'h0, wd_alarm});
    n = 0;
    while (wd_alarm !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("wd_delay", 32'h1, {31'h0, n >= 15 && n <= 25});
    if (n >= 40) results();
    chk("wd_alarm", 32'h1, {31'h0, wd_alarm});
    chk("dout_on", 32'h8001, {16'h0, dout_on});
    ask(1'b0, 8'h05, 16'h0001, 16'h0000, 8'h00, 16'h0000);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("wd_alarm", 32'h0, {31'h0, wd_alarm});
    load(1'b0, 16'h000a, 8'h05);
  endtask : t_wdog

  // ==========================================================================
  // Main sequence.
  initial begin
    rst        = 1'b1;
    cfg_wr     = 1'b0;
    cfg        = '0;
    rbe_en     = 1'b0;
    upd        = '0;
    din_pin    = 16'hfffe;
    ain_raw    = '0;
    ain_raw[7] = 16'h7fff;
    ain_raw[0] = 16'h1999;
    fails      = 0;
    cmp_count  = 0;
    fwd_cnt    = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    t_reset();
    t_points();
    t_store();
    t_wdog();
    results();
  end
endmodule : testbench
`default_nettype wire
